// ==== rtl/oad_pkg.sv ====
// Constants, enumerations and carriers of the operand addressing decoder
package oad_pkg;

  // Widths and stack depth
  localparam int unsigned OAD_PC_W    = 12;
  localparam int unsigned OAD_DA_W    = 8;
  localparam int unsigned OAD_STK_DEP = 6;

  // Working and pointer register addresses
  localparam logic [7:0] OAD_WREG_BASE = 8'h80;
  localparam logic [7:0] OAD_WREG_LAST = 8'h83;
  localparam logic [7:0] OAD_PTR_X     = 8'h80;
  localparam logic [7:0] OAD_PTR_Y     = 8'h81;

  // Data space regions outside the working registers
  localparam logic [7:0] OAD_ACC_ADDR  = 8'hff;
  localparam logic [7:0] OAD_ROM_LO    = 8'h00;
  localparam logic [7:0] OAD_ROM_HI    = 8'h3f;
  localparam logic [7:0] OAD_RAM_LO    = 8'h84;
  localparam logic [7:0] OAD_RAM_HI    = 8'hbf;

  // Opcode field positions
  localparam int unsigned OAD_EXT_HI_LSB = 0;
  localparam int unsigned OAD_SPAN_LSB   = 0;
  localparam int unsigned OAD_DIR_BIT    = 4;
  localparam int unsigned OAD_COND_LSB   = 5;
  localparam int unsigned OAD_IND_SEL    = 4;
  localparam int unsigned OAD_SDIR_LSB   = 0;
  localparam int unsigned OAD_BITN_LSB   = 5;

  // Instruction lengths in bytes
  localparam logic [1:0] OAD_LEN1 = 2'h1;
  localparam logic [1:0] OAD_LEN2 = 2'h2;
  localparam logic [1:0] OAD_LEN3 = 2'h3;

  // Addressing modes, one-hot
  typedef enum logic [8:0] {
    OAD_M_IMM   = 9'h001,
    OAD_M_DIR   = 9'h002,
    OAD_M_SDIR  = 9'h004,
    OAD_M_EXT   = 9'h008,
    OAD_M_REL   = 9'h010,
    OAD_M_BDIR  = 9'h020,
    OAD_M_BTST  = 9'h040,
    OAD_M_IND   = 9'h080,
    OAD_M_INH   = 9'h100
  } oad_mode_t;

  // Data space regions, one-hot
  typedef enum logic [4:0] {
    OAD_R_ACC    = 5'h01,
    OAD_R_WREG   = 5'h02,
    OAD_R_PERIPH = 5'h04,
    OAD_R_RAM    = 5'h08,
    OAD_R_ROM    = 5'h10
  } oad_region_t;

  typedef struct packed {
    logic                valid;
    oad_mode_t           mode;
    logic [7:0]          opcode;
    logic [7:0]          byte1;
    logic [7:0]          byte2;
    logic [OAD_PC_W-1:0] pc;
    logic                cond_true;
  } oad_req_t;

  typedef struct packed {
    logic                valid;
    logic [1:0]          len;
    logic                daddr_valid;
    logic [7:0]          daddr;
    oad_region_t         region;
    logic                imm_valid;
    logic [7:0]          imm;
    logic [2:0]          bit_num;
    logic [7:0]          bit_mask;
    logic [2:0]          cond;
    logic                redirect;
    logic [OAD_PC_W-1:0] target;
    logic [OAD_PC_W-1:0] next_pc;
  } oad_res_t;

endpackage

// ==== rtl/oad_decoder.sv ====
// Operand address and branch target decoder with return-address stack
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: Keep program, data and stack spaces apart in separate outputs.
// RULE2: Stack holds six 12-bit return addresses pushed on calls and interrupts.
// RULE3: Classify data addresses as accumulator, working register, peripheral, RAM or ROM.
// RULE4: Immediate mode takes the byte after the opcode as constant operand.
// RULE5: Direct mode uses the byte after the opcode as data address.
// RULE6: Short direct opcode selects one working register at 80h to 83h.
// RULE7: Extended mode target is opcode low nibble above the next byte.
// RULE8: Relative branch reaches -15 to +16 when taken, else next instruction.
// RULE9: Relative opcode holds condition, direction bit and four-bit span.
// RULE10: Bit direct opcode gives bit number, next byte gives its address.
// RULE11: Bit test branch is three bytes: opcode, address, displacement -127..+128.
// RULE12: Indirect mode uses pointer at 80h or 81h chosen by opcode bit 4.
// RULE13: Inherent opcode needs no operand or address bytes.
// RULE14: Any data-space bit can be set, cleared or tested.
// RULE15: Bit test displacement counts from the bit test instruction address.
module oad_decoder
  import oad_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                rst_in,
  input  wire oad_req_t            req_in,
  input  wire logic [7:0]          ptr_x_in,
  input  wire logic [7:0]          ptr_y_in,
  input  wire logic                push_in,
  input  wire logic                pop_in,
  input  wire logic [OAD_PC_W-1:0] push_addr_in,
  output oad_res_t                 res_out,
  output logic [OAD_PC_W-1:0]      stack_top_out,
  output logic [2:0]               stack_depth_out
);

  oad_res_t            res_d, res_q;
  logic [OAD_PC_W-1:0] stk_d [OAD_STK_DEP];
  logic [OAD_PC_W-1:0] stk_q [OAD_STK_DEP];
  logic [2:0]          dep_d, dep_q;

  // Region lookup of a data address
  function automatic oad_region_t region_of(input logic [7:0] a);
    oad_region_t r;
    r = OAD_R_PERIPH;
    if (a == OAD_ACC_ADDR) begin
      r = OAD_R_ACC;
    end else if (a >= OAD_WREG_BASE && a <= OAD_WREG_LAST) begin
      r = OAD_R_WREG;
    end else if (a >= OAD_RAM_LO && a <= OAD_RAM_HI) begin
      r = OAD_R_RAM;
    end else if (a <= OAD_ROM_HI) begin
      r = OAD_R_ROM;
    end
    return r;
  endfunction

  // Decode of one instruction; outputs registered so downstream sees stable data
  always_comb begin
    logic [OAD_PC_W-1:0] npc;
    logic [3:0]          span;
    npc            = '0;
    span           = '0;
    res_d          = '0;
    res_d.region   = OAD_R_PERIPH;
    res_d.valid    = req_in.valid;
    res_d.len      = OAD_LEN1;                                  // RULE13
    span           = req_in.opcode[OAD_SPAN_LSB +: 4];           // RULE9
    res_d.cond     = req_in.opcode[OAD_COND_LSB +: 3];           // RULE9
    res_d.bit_num  = req_in.opcode[OAD_BITN_LSB +: 3];           // RULE10
    res_d.bit_mask = 8'h01 << res_d.bit_num;                     // RULE14
    unique case (req_in.mode)
      OAD_M_IMM: begin
        res_d.len       = OAD_LEN2;
        res_d.imm_valid = 1'b1;                                  // RULE4
        res_d.imm       = req_in.byte1;                          // RULE4
      end
      OAD_M_DIR, OAD_M_BDIR: begin
        res_d.len         = OAD_LEN2;
        res_d.daddr_valid = 1'b1;
        res_d.daddr       = req_in.byte1;                        // RULE5 RULE10
      end
      OAD_M_SDIR: begin
        res_d.daddr_valid = 1'b1;
        res_d.daddr       = OAD_WREG_BASE
                            + {6'h00, req_in.opcode[OAD_SDIR_LSB +: 2]}; // RULE6
      end
      OAD_M_EXT: begin
        res_d.len = OAD_LEN2;
      end
      OAD_M_BTST: begin
        res_d.len         = OAD_LEN3;                            // RULE11
        res_d.daddr_valid = 1'b1;
        res_d.daddr       = req_in.byte1;                        // RULE11
      end
      OAD_M_IND: begin
        res_d.daddr_valid = 1'b1;
        res_d.daddr       = req_in.opcode[OAD_IND_SEL] ? ptr_y_in : ptr_x_in; // RULE12
      end
      default: begin
        res_d.len = OAD_LEN1;                                    // Relative, inherent
      end
    endcase
    if (res_d.daddr_valid) begin
      res_d.region = region_of(res_d.daddr);                     // RULE3
    end
    npc           = req_in.pc + OAD_PC_W'(res_d.len);
    res_d.next_pc = npc;
    res_d.target  = npc;
    // Program space targets; only these modes may redirect the fetch
    if (req_in.mode == OAD_M_EXT) begin
      res_d.redirect = 1'b1;
      res_d.target   = {req_in.opcode[OAD_EXT_HI_LSB +: 4], req_in.byte1}; // RULE7
    end else if (req_in.mode == OAD_M_REL && req_in.cond_true) begin
      res_d.redirect = 1'b1;
      res_d.target   = req_in.opcode[OAD_DIR_BIT]
                       ? req_in.pc - OAD_PC_W'(span)               // RULE8
                       : req_in.pc + OAD_PC_W'(span) + 12'h001;    // RULE8
    end else if (req_in.mode == OAD_M_BTST && req_in.cond_true) begin
      res_d.redirect = 1'b1;
      res_d.target   = req_in.pc + {{4{req_in.byte2[7]}}, req_in.byte2}
                       + 12'h001;                                  // RULE11 RULE15
    end
  end

  // Result register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

  assign res_out = res_q;                                        // RULE1

  // Stack next state; a seventh push drops the oldest entry silently
  always_comb begin
    for (int i = 0; i < OAD_STK_DEP; i++) begin
      stk_d[i] = stk_q[i];
    end
    dep_d = dep_q;
    if (push_in && pop_in) begin
      stk_d[0] = push_addr_in;                                   // RULE2
    end else if (push_in) begin
      for (int i = OAD_STK_DEP - 1; i > 0; i--) begin
        stk_d[i] = stk_q[i-1];
      end
      stk_d[0] = push_addr_in;                                   // RULE2
      if (dep_q != 3'(OAD_STK_DEP)) begin
        dep_d = dep_q + 3'h1;
      end
    end else if (pop_in) begin
      for (int i = 0; i < OAD_STK_DEP - 1; i++) begin
        stk_d[i] = stk_q[i+1];
      end
      stk_d[OAD_STK_DEP-1] = '0;
      if (dep_q != 3'h0) begin
        dep_d = dep_q - 3'h1;
      end
    end
  end

  // Stack registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < OAD_STK_DEP; i++) begin
        stk_q[i] <= '0;
      end
      dep_q <= 3'h0;
    end else begin
      for (int i = 0; i < OAD_STK_DEP; i++) begin
        stk_q[i] <= stk_d[i];
      end
      dep_q <= dep_d;
    end
  end

  assign stack_top_out   = stk_q[0];
  assign stack_depth_out = dep_q;

  // Checks on the decoded results and the return-address stack
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_imm_operand: assert property (req_in.valid && req_in.mode == OAD_M_IMM |=> // RULE4
    res_q.imm_valid && res_q.imm == $past(req_in.byte1) && res_q.len == 2'h2)
    else $error("immediate operand wrong");
  a_direct_addr: assert property (req_in.valid && req_in.mode == OAD_M_DIR |=> // RULE5
    res_q.daddr_valid && res_q.daddr == $past(req_in.byte1))
    else $error("direct address wrong");
  a_short_wreg: assert property (req_in.valid && req_in.mode == OAD_M_SDIR |=> // RULE6
    res_q.daddr >= 8'h80 && res_q.daddr <= 8'h83 && res_q.len == 2'h1
    && res_q.region == OAD_R_WREG)
    else $error("short direct outside working registers");
  a_ext_target: assert property (req_in.valid && req_in.mode == OAD_M_EXT |=> // RULE7
    res_q.redirect && res_q.target == {$past(req_in.opcode[3:0]), $past(req_in.byte1)})
    else $error("extended target wrong");
  a_rel_span: assert property (req_in.valid && req_in.mode == OAD_M_REL |=> // RULE8
    (res_q.redirect
     ? (res_q.target - $past(req_in.pc) <= 12'h010
        || $past(req_in.pc) - res_q.target <= 12'h00f)
     : res_q.target == $past(req_in.pc) + 12'h001))
    else $error("relative branch out of span");
  a_rel_back: assert property (req_in.valid && req_in.mode == OAD_M_REL // RULE9
    && req_in.cond_true && req_in.opcode[4] |=>
    res_q.target == $past(req_in.pc) - {8'h00, $past(req_in.opcode[3:0])})
    else $error("backward branch wrong");
  a_btst_target: assert property (req_in.valid && req_in.mode == OAD_M_BTST // RULE15
    && req_in.cond_true |=> res_q.len == 2'h3 && res_q.next_pc == $past(req_in.pc) + 12'h003
    && res_q.target == $past(req_in.pc) + {{4{$past(req_in.byte2[7])}}, $past(req_in.byte2)}
       + 12'h001)
    else $error("bit test target wrong");
  a_bit_mask: assert property (req_in.valid && req_in.mode == OAD_M_BDIR |=> // RULE10
    res_q.bit_mask == (8'h01 << $past(req_in.opcode[7:5])) && res_q.daddr_valid)
    else $error("bit mask wrong");
  a_ind_ptr: assert property (req_in.valid && req_in.mode == OAD_M_IND |=> // RULE12
    res_q.daddr == ($past(req_in.opcode[4]) ? $past(ptr_y_in) : $past(ptr_x_in)))
    else $error("indirect pointer wrong");
  a_inh_len: assert property (req_in.valid && req_in.mode == OAD_M_INH |=> // RULE13
    res_q.len == 2'h1 && !res_q.daddr_valid && !res_q.imm_valid && !res_q.redirect)
    else $error("inherent fetches operands");
  a_stack_lifo: assert property (push_in && !pop_in ##1 !push_in && pop_in |=> // RULE2
    stack_top_out == $past(stack_top_out, 2))
    else $error("stack push and pop not paired");
  a_stack_depth: assert property (stack_depth_out <= 3'h6) // RULE2
    else $error("stack depth above six");

  c_rel_taken: cover property (req_in.valid && req_in.mode == OAD_M_REL && req_in.cond_true);
  c_btst_back: cover property (req_in.valid && req_in.mode == OAD_M_BTST && req_in.byte2[7]);
  c_stack_full: cover property (stack_depth_out == 3'h6 && push_in);
  c_ind_y: cover property (req_in.valid && req_in.mode == OAD_M_IND && req_in.opcode[4]);

endmodule

`default_nettype wire

// ==== sim/oad_mem_model.sv ====
// Program and data memory model facing the decoder
`timescale 1ns/1ps
`default_nettype none
module oad_mem_model
  import oad_pkg::*;
(
  input  wire logic [OAD_PC_W-1:0] fetch_pc_in,
  output logic [7:0]               opcode_out,
  output logic [7:0]               byte1_out,
  output logic [7:0]               byte2_out,
  output logic [7:0]               ptr_x_out,
  output logic [7:0]               ptr_y_out
);
  // Separate arrays for program and data space
  logic [7:0] prog [0:4095];
  logic [7:0] data [0:255];

  // Instruction bytes follow the opcode; address wraps at 4 Kbyte
  assign opcode_out = prog[fetch_pc_in];
  assign byte1_out  = prog[fetch_pc_in + 12'h001];
  assign byte2_out  = prog[fetch_pc_in + 12'h002];

  // Pointer registers live in data space
  assign ptr_x_out = data[OAD_PTR_X];
  assign ptr_y_out = data[OAD_PTR_Y];

  // Unwritten cells hold a varying pattern so stale bytes never pass
  initial begin
    for (int i = 0; i < 4096; i++) prog[i] = i[7:0] ^ 8'ha5;
    for (int i = 0; i < 256; i++) data[i] = i[7:0] ^ 8'h3c;
  end
endmodule
`default_nettype wire

// ==== sim/operand_addressing_decoder_bench.sv ====
// Self-checking bench of the operand addressing decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module operand_addressing_decoder_bench
  import oad_pkg::*;
;
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic        vld     = 1'b0;
  logic        cnd     = 1'b0;
  logic        push    = 1'b0;
  logic        pop     = 1'b0;
  oad_mode_t   mode    = OAD_M_INH;
  logic [11:0] pc      = 12'h000;
  logic [11:0] paddr   = 12'h000;
  logic [7:0]  opc, b1, b2, px, py;
  oad_req_t    req;
  oad_res_t    res;
  logic [11:0] top;
  logic [2:0]  dep;
  int          err_count = 0;
  int          comparisons = 0;

  // Request bytes come from program memory at the instruction address
  assign req = '{vld, mode, opc, b1, b2, pc, cnd};
  always #20 mclk_in = ~mclk_in;

  oad_mem_model mem (.fetch_pc_in(pc), .opcode_out(opc), .byte1_out(b1),
    .byte2_out(b2), .ptr_x_out(px), .ptr_y_out(py));
  oad_decoder DUT (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req),
    .ptr_x_in(px), .ptr_y_in(py), .push_in(push), .pop_in(pop),
    .push_addr_in(paddr), .res_out(res), .stack_top_out(top),
    .stack_depth_out(dep));

  // One decode: load bytes, present request, sample after fixed latency
  task automatic dec(oad_mode_t m, logic [11:0] a, logic [7:0] o, x, y, logic c);
    @(negedge mclk_in);
    mem.prog[a] = o;
    mem.prog[a + 12'h001] = x;
    mem.prog[a + 12'h002] = y;
    @(posedge mclk_in);
    vld <= 1'b1;
    mode <= m;
    pc <= a;
    cnd <= c;
    @(posedge mclk_in);
    vld <= 1'b0;
    #1;
    `CHK(res.valid, 1'b1)
  endtask

  task automatic t_ext();
    dec(OAD_M_EXT, 12'h100, 8'h35, 8'h7a, 8'h5a, 1'b0);
    `CHK(res.target, 12'h57a)
    `CHK(res.redirect, 1'b1)
    `CHK(res.len, OAD_LEN2)
  endtask

  // Span limits both ways, taken and not taken
  task automatic t_rel();
    logic [7:0]  o [5] = '{8'hef, 8'h3f, 8'h40, 8'h30, 8'hef};
    logic        c [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [11:0] t [5] = '{12'h210, 12'h1f1, 12'h201, 12'h200, 12'h201};
    for (int i = 0; i < 5; i++) begin
      dec(OAD_M_REL, 12'h200, o[i], 8'h5a, 8'h5a, c[i]);
      `CHK(res.target, t[i])
      `CHK(res.cond, o[i][7:5])
      `CHK(res.len, OAD_LEN1)
    end
  endtask

  // Direct addresses at ROM and RAM ends, 80h, C0h and FFh
  task automatic t_dir();
    logic [7:0]  a [7] = '{8'h00, 8'h3f, 8'h80, 8'h84, 8'hbf, 8'hc0, 8'hff};
    oad_region_t r [7] = '{OAD_R_ROM, OAD_R_ROM, OAD_R_WREG, OAD_R_RAM,
                           OAD_R_RAM, OAD_R_PERIPH, OAD_R_ACC};
    for (int i = 0; i < 7; i++) begin
      dec(OAD_M_DIR, 12'h020, 8'h1f, a[i], 8'h5a, 1'b0);
      `CHK(res.daddr, a[i])
      `CHK(res.daddr_valid, 1'b1)
      `CHK(res.region, r[i])
      `CHK(res.len, OAD_LEN2)
    end
  endtask

  task automatic t_sdir_bit();
    for (int i = 0; i < 4; i++) begin
      dec(OAD_M_SDIR, 12'h030, 8'h2c | 8'(i), 8'h5a, 8'h5a, 1'b0);
      `CHK(res.daddr, 8'h80 + 8'(i))
      `CHK(res.len, OAD_LEN1)
    end
    for (int n = 0; n < 8; n++) begin
      dec(OAD_M_BDIR, 12'h050, {3'(n), 5'h1b}, 8'hc5, 8'h5a, 1'b0);
      `CHK(res.daddr, 8'hc5)
      `CHK(res.bit_num, 3'(n))
      `CHK(res.bit_mask, 8'h01 << n)
      `CHK(res.len, OAD_LEN2)
    end
  endtask

  // Displacement extremes, then a test that fails
  task automatic t_btst();
    logic [7:0]  d [3] = '{8'h7f, 8'h80, 8'h7f};
    logic        c [3] = '{1'b1, 1'b1, 1'b0};
    logic [11:0] t [3] = '{12'h380, 12'h281, 12'h303};
    for (int i = 0; i < 3; i++) begin
      dec(OAD_M_BTST, 12'h300, 8'ha3, 8'h9d, d[i], c[i]);
      `CHK(res.target, t[i])
      `CHK(res.len, OAD_LEN3)
      `CHK(res.daddr, 8'h9d)
      `CHK(res.bit_num, 3'h5)
    end
  endtask

  task automatic t_misc();
    mem.data[8'h80] = 8'h9c;
    mem.data[8'h81] = 8'h4e;
    dec(OAD_M_IND, 12'h060, 8'h07, 8'h5a, 8'h5a, 1'b0);
    `CHK(res.daddr, 8'h9c)
    dec(OAD_M_IND, 12'h061, 8'h17, 8'h5a, 8'h5a, 1'b0);
    `CHK(res.daddr, 8'h4e)
    `CHK(res.len, OAD_LEN1)
    dec(OAD_M_IMM, 12'h040, 8'h17, 8'hc3, 8'h5a, 1'b0);
    `CHK(res.imm, 8'hc3)
    `CHK(res.imm_valid, 1'b1)
    `CHK(res.next_pc, 12'h042)
    // Last program address: next address must wrap
    dec(OAD_M_INH, 12'hfff, 8'h04, 8'h5a, 8'h5a, 1'b0);
    `CHK(res.len, OAD_LEN1)
    `CHK({res.imm_valid, res.daddr_valid, res.redirect}, 3'h0)
    `CHK(res.next_pc, 12'h000)
  endtask

  // Overfill by one, pop one, then pop past empty
  task automatic t_stack();
    for (int i = 1; i <= 7; i++) begin
      @(posedge mclk_in);
      push <= 1'b1;
      paddr <= 12'h100 + 12'(i);
    end
    @(posedge mclk_in);
    push <= 1'b0;
    #1;
    `CHK(dep, 3'h6)
    `CHK(top, 12'h107)
    @(posedge mclk_in);
    pop <= 1'b1;
    @(posedge mclk_in);
    pop <= 1'b0;
    #1;
    `CHK(top, 12'h106)
    `CHK(dep, 3'h5)
    @(posedge mclk_in);
    pop <= 1'b1;
    repeat (6) @(posedge mclk_in);
    pop <= 1'b0;
    #1;
    `CHK({dep, top}, 15'h0000)
    // Two pushes then a pop back to back, then push and pop in one cycle
    @(posedge mclk_in);
    push  <= 1'b1;
    paddr <= 12'h2a5;
    @(posedge mclk_in);
    paddr <= 12'h2b6;
    @(posedge mclk_in);
    push <= 1'b0;
    pop  <= 1'b1;
    @(posedge mclk_in);
    push  <= 1'b1;
    paddr <= 12'h2c7;
    #1;
    `CHK({dep, top}, 15'h12a5)
    @(posedge mclk_in);
    push <= 1'b0;
    pop  <= 1'b0;
    #1;
    `CHK({dep, top}, 15'h12c7)
  endtask

  // Mid-run reset clears results and stack; request allowed right after release
  task automatic t_reset();
    mem.prog[12'h0a0] = 8'h3b;
    mem.prog[12'h0a1] = 8'h6d;
    @(posedge mclk_in);
    rst_in <= 1'b1;
    mode   <= OAD_M_EXT;
    pc     <= 12'h0a0;
    repeat (2) @(posedge mclk_in);
    #1;
    `CHK({res.valid, res.redirect, res.target, dep, top}, 29'h0000000)
    @(posedge mclk_in);
    rst_in <= 1'b0;
    vld    <= 1'b1;
    @(posedge mclk_in);
    vld <= 1'b0;
    #1;
    `CHK({res.valid, res.target}, 13'h1b6d)
  endtask

  task automatic conclude();
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_ext();
    t_rel();
    t_dir();
    t_sdir_bit();
    t_btst();
    t_misc();
    t_stack();
    t_reset();
    conclude();
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge mclk_in);
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
